// ==== rtl/router_pkg.sv ====
package router_pkg;

	// ****************************************
	// Packet format
	// ****************************************
	localparam int PKT_W     = 72;     // Long packet
	localparam int SHORT_W   = 40;     // Short packet
	localparam int LEN_W     = 2;      // Length code width
	localparam logic [1:0] LEN_SHORT = 2'h1;
	localparam logic [1:0] LEN_LONG  = 2'h2;
	localparam int PAR_BIT   = 0;      // Odd parity over packet
	localparam int PHASE_LSB = 4;      // Two-bit time phase
	localparam int TYPE_LSB  = 6;      // Two-bit packet type
	localparam int KEY_LSB   = 8;      // Multicast source key
	localparam int KEY_W     = 32;
	localparam int DID_LSB   = 8;      // Pairwise destination id
	localparam int DID_W     = 16;

	// Packet types
	typedef enum logic [1:0] {
		PT_GRP  = 2'h0,
		PT_DIR  = 2'h1,
		PT_NBR  = 2'h2,
		PT_EMER = 2'h3
	} ptype_t;

	// ****************************************
	// Fabric geometry
	// ****************************************
	localparam int LINKS    = 6;       // Output link transmitters
	localparam int TAG_W    = 3;       // Arrival interface tag
	localparam int OPP_STEP = 3;       // Opposite link distance
	localparam logic [1:0] AGE_OLD = 2'h2;

	// ****************************************
	// Error flags
	// ****************************************
	localparam int ERR_W    = 4;
	localparam int ERR_PAR  = 0;
	localparam int ERR_AGE  = 1;
	localparam int ERR_LEN  = 2;
	localparam int ERR_LINK = 3;

	// ****************************************
	// Tables
	// ****************************************
	localparam int DIR_EW       = 8;
	localparam int DIR_MON      = 0;
	localparam int DIR_LINK_LSB = 1;
	localparam logic [1:0] CFG_KEY   = 2'h0;
	localparam logic [1:0] CFG_MASK  = 2'h1;
	localparam logic [1:0] CFG_ROUTE = 2'h2;
	localparam logic [1:0] CFG_DIR   = 2'h3;

endpackage : router_pkg

// ==== rtl/router_link_if.sv ====
`timescale 1ns/1ps
interface router_link_if #(
	parameter int PROCS = 20
);
	import router_pkg::*;
	localparam int DV_W = LINKS + PROCS;

	// Arbiter to router
	logic                 valid;
	logic                 ready;
	logic [PKT_W-1:0]     pkt;
	logic [LEN_W-1:0]     len;
	logic [TAG_W-1:0]     tag;
	// Router to destination buffers
	logic                 out_valid;
	logic                 out_ready;
	logic [DV_W-1:0]      dest;
	logic [PKT_W-1:0]     out_pkt;
	logic [LEN_W-1:0]     out_len;
	logic [ERR_W-1:0]     out_err;
	// Full indications per output link
	logic [LINKS-1:0]     full;

	modport router (
		input  valid, pkt, len, tag, out_ready, full,
		output ready, out_valid, dest, out_pkt, out_len, out_err
	);
	modport feeder (
		output valid, pkt, len, tag, out_ready, full,
		input  ready, out_valid, dest, out_pkt, out_len, out_err
	);

endinterface : router_link_if

// ==== rtl/packet_router.sv ====
`timescale 1ns/1ps
// Behaviour
// R01: Accept whole 40 or 72 bit packets
// R02: Arbiter supplies arrival interface tag
// R03: Check errors before any routing engine
// R04: Multicast only for clean multicast packets
// R05: Steer packets to pairwise or rule engine
// R06: Output one flag per link and processor
// R07: Any mix of links and processors
// R08: Detect full links, reroute their packets
// R09: Merged copies carry emergency type
// R10: 1024 key entries with per-entry masks
// R11: Unmatched multicast takes default route
// R12: Flag parity, age, link, length faults
// R13: Management processor gets special packets
// R14: One at a time, order kept
// R15: Two-input arbiter tree merges inputs
// R16: Each merge appends one source bit
// R17: Half-packet buffer where width grows; every node here buffers a whole packet
// R18: Each link resettable on its own
// R19: Keep phase, stamp local packets
// R20: Twice-aged off-chip packets go to management
// R21: Pairwise table, eight-bit entries
// R22: Default route to opposite link
// R23: Valid/ready between stages, backpressure
// R24: Erroneous packets only reach management; link-fault packets still go to their unblocked links as well
module packet_router #(
	parameter int PROCS      = 20,
	parameter int AM_N       = 1024,
	parameter int DIR_AW     = 16,
	parameter int BLOCK_WAIT = 16
)(
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           nrst,
	// Arbiter and output buffers
	router_link_if.router                       lnk,
	// Table programming
	input  wire logic                           cfg_we,
	input  wire logic [1:0]                     cfg_sel,
	input  wire logic [DIR_AW-1:0]              cfg_addr,
	input  wire logic [31:0]                    cfg_data,
	// Management
	input  wire logic [$clog2(PROCS)-1:0]       mon_id,
	input  wire logic                           phase_tick,
	input  wire logic [router_pkg::LINKS-1:0]   link_reset,
	// Status
	output logic [1:0]                          cur_phase,
	output logic [router_pkg::LINKS-1:0]        link_blocked,
	output logic [router_pkg::ERR_W-1:0]        last_err
);
	import router_pkg::*;

	localparam int DV_W  = LINKS + PROCS;
	localparam int AM_AW = $clog2(AM_N);
	localparam int BW_W  = $clog2(BLOCK_WAIT + 1);

	// ****************************************
	// Helpers
	// ****************************************
	// Bits that belong to the packet length
	function automatic logic [PKT_W-1:0] len_mask(input logic [1:0] len);
		len_mask = (len == LEN_LONG) ? {PKT_W{1'b1}} :
			{{(PKT_W-SHORT_W){1'b0}}, {SHORT_W{1'b1}}};
	endfunction : len_mask

	// Restore odd parity after a field was rewritten
	function automatic logic [PKT_W-1:0] fix_par(input logic [PKT_W-1:0] p,
		input logic [1:0] len);
		logic [PKT_W-1:0] q;
		q          = p;
		q[PAR_BIT] = 1'b0;
		q[PAR_BIT] = ~^(q & len_mask(len));
		fix_par    = q;
	endfunction : fix_par

	// Destination vector selecting the management processor
	function automatic logic [DV_W-1:0] mon_vec(input logic [$clog2(PROCS)-1:0] id);
		logic [DV_W-1:0] v;
		v = '0;
		if (int'(id) < PROCS) begin
			v[LINKS + int'(id)] = 1'b1;
		end
		mon_vec = v;
	endfunction : mon_vec

	// ****************************************
	// Stage handshake
	// ****************************************
	logic                 s1_v, s2_v, s3_v;       // Stage occupancy
	logic [PKT_W-1:0]     s1_pkt, s2_pkt, s3_pkt; // Packet words
	logic [LEN_W-1:0]     s1_len, s2_len, s3_len; // Length codes
	logic [TAG_W-1:0]     s1_tag, s2_tag;         // Arrival tags
	logic [ERR_W-1:0]     s2_err, s3_err;         // Carried errors
	logic [DV_W-1:0]      s3_dv;                  // Routed vector

	// R23: stage advance
	wire logic out_free = !lnk.out_valid || lnk.out_ready;
	wire logic s3_free  = !s3_v || out_free;
	wire logic s2_free  = !s2_v || s3_free;
	wire logic take     = lnk.valid && lnk.ready;

	// Capture; ready is a flop so it only opens on an empty stage
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_v      <= 1'b0;
			lnk.ready <= 1'b0;
		end else begin
			// R01: whole packet in one transfer
			if (take) begin
				s1_v   <= 1'b1;
				s1_pkt <= lnk.pkt;
				s1_len <= lnk.len;
				// R02: keep arrival interface
				s1_tag <= lnk.tag;
			end else if (s2_free) begin
				s1_v <= 1'b0;
			end
			// R14: one packet at a time
			lnk.ready <= !(take || (s1_v && !s2_free));
		end
	end

	// ****************************************
	// Error check stage
	// ****************************************
	wire logic       len_ok  = (s1_len == LEN_SHORT) || (s1_len == LEN_LONG);
	wire logic       par_bad = len_ok && !(^(s1_pkt & len_mask(s1_len)));
	wire logic       offchip = int'(s1_tag) < LINKS;
	wire logic [1:0] old_ph  = 2'(cur_phase - AGE_OLD);
	wire logic       aged    = offchip && (s1_pkt[PHASE_LSB +: 2] == old_ph);
	logic [ERR_W-1:0] s1_err;     // Faults found here
	logic [PKT_W-1:0] s1_stamp;   // Packet with local phase

	// R12: packet faults
	always_comb begin
		s1_err           = '0;
		s1_err[ERR_PAR]  = par_bad;
		// R20: twice-aged off-chip packet
		s1_err[ERR_AGE]  = aged;
		s1_err[ERR_LEN]  = !len_ok;
		s1_stamp         = s1_pkt;
		// R19: stamp only clean local packets, never masking a fault
		if (!offchip && !par_bad && len_ok) begin
			s1_stamp[PHASE_LSB +: 2] = cur_phase;
			s1_stamp = fix_par(s1_stamp, s1_len);
		end
	end

	// R03: faults registered before routing
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s2_v <= 1'b0;
		end else if (s2_free) begin
			s2_v   <= s1_v;
			s2_pkt <= s1_stamp;
			s2_len <= s1_len;
			s2_tag <= s1_tag;
			s2_err <= s1_err;
		end
	end

	// R19: phase counter
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cur_phase <= '0;
		end else if (phase_tick) begin
			cur_phase <= 2'(cur_phase + 2'h1);
		end
	end

	// ****************************************
	// Routing tables
	// ****************************************
	logic [KEY_W-1:0]   am_key   [AM_N];     // Match keys
	logic [KEY_W-1:0]   am_mask  [AM_N];     // Don't-care bits
	logic [DV_W-1:0]    am_route [AM_N];     // Route words
	logic [AM_N-1:0]    am_on;               // Entry in use
	logic [DIR_EW-1:0]  dir_tab  [2**DIR_AW];

	wire logic [AM_AW-1:0] am_wa = cfg_addr[AM_AW-1:0];

	// R10: programmable entries
	always_ff @(posedge clk) begin
		if (cfg_we) begin
			case (cfg_sel)
				CFG_KEY:   am_key[am_wa]   <= cfg_data[KEY_W-1:0];
				CFG_MASK:  am_mask[am_wa]  <= cfg_data[KEY_W-1:0];
				CFG_ROUTE: am_route[am_wa] <= cfg_data[DV_W-1:0];
				// R21: pairwise table entry
				default:   dir_tab[cfg_addr] <= cfg_data[DIR_EW-1:0];
			endcase
		end
	end

	// Entry goes live when its key is written
	always_ff @(posedge clk) begin
		if (!nrst) begin
			am_on <= '0;
		end else if (cfg_we && cfg_sel == CFG_KEY) begin
			am_on[am_wa] <= 1'b1;
		end
	end

	// ****************************************
	// Routing stage
	// ****************************************
	wire ptype_t         s2_type = ptype_t'(s2_pkt[TYPE_LSB +: 2]);
	wire logic [KEY_W-1:0] key   = s2_pkt[KEY_LSB +: KEY_W];
	wire logic           s2_off  = int'(s2_tag) < LINKS;
	logic [AM_N-1:0]     am_hit;
	logic [AM_AW-1:0]    am_idx;

	// R10: masked compare on every entry
	for (genvar i = 0; i < AM_N; i++) begin : g_cam
		assign am_hit[i] = am_on[i] && (((key ^ am_key[i]) & ~am_mask[i]) == '0);
	end

	// Lowest matching entry wins
	function automatic logic [AM_AW-1:0] first_hit(input logic [AM_N-1:0] h);
		first_hit = '0;
		for (int i = AM_N - 1; i >= 0; i--) begin
			if (h[i]) begin
				first_hit = AM_AW'(i);
			end
		end
	endfunction : first_hit

	assign am_idx = first_hit(am_hit);

	wire logic [DIR_EW-1:0] dir_ent = dir_tab[s2_pkt[DID_LSB +: DIR_AW]];
	wire logic              dir_ok  = ^dir_ent;
	wire logic [DV_W-1:0]   mon_dv  = mon_vec(mon_id);
	logic [DV_W-1:0]        route_dv;     // Chosen destinations
	int                     opp;          // Opposite link

	// R05: engine selection
	always_comb begin
		opp      = int'(s2_tag) + OPP_STEP;
		route_dv = '0;
		if (opp >= LINKS) begin
			opp = opp - LINKS;
		end
		// R24: faulty packet to management only
		if (|s2_err) begin
			route_dv = mon_dv;
		end else begin
			case (s2_type)
				// R04: multicast only when clean
				PT_GRP, PT_EMER: begin
					if (|am_hit) begin
						// R06: one flag per destination
						route_dv = am_route[am_idx];
					// R11: unmatched still delivered
					end else if (s2_off) begin
						// R22: opposite link
						route_dv[opp] = 1'b1;
					end else begin
						route_dv = mon_dv;
					end
				end
				// R21: pairwise entry, parity checked
				PT_DIR: begin
					if (!dir_ok) begin
						route_dv = mon_dv;
					end else begin
						// R07: links and management mix
						route_dv[LINKS-1:0] = dir_ent[DIR_LINK_LSB +: LINKS];
						if (dir_ent[DIR_MON]) begin
							route_dv = route_dv | mon_dv;
						end
					end
				end
				// R13: arriving neighbour packets terminate here
				default: begin
					if (s2_off) begin
						route_dv = mon_dv;
					end else begin
						route_dv[LINKS-1:0] = '1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s3_v <= 1'b0;
		end else if (s3_free) begin
			s3_v   <= s2_v;
			s3_pkt <= s2_pkt;
			s3_len <= s2_len;
			s3_err <= s2_err;
			s3_dv  <= route_dv;
		end
	end

	// ****************************************
	// Emergency stage
	// ****************************************
	// Sustained full marks a link blocked; it clears once drained
	for (genvar l = 0; l < LINKS; l++) begin : g_blk
		logic [BW_W-1:0] full_cnt;    // Cycles held full
		logic            blk;         // Link judged blocked
		assign link_blocked[l] = blk;
		always_ff @(posedge clk) begin
			// R18: per-link reset
			if (!nrst || link_reset[l]) begin
				full_cnt <= '0;
				blk      <= 1'b0;
			// R08: full indication watched
			end else if (!lnk.full[l]) begin
				full_cnt <= '0;
				blk      <= 1'b0;
			end else if (full_cnt == BW_W'(BLOCK_WAIT)) begin
				blk <= 1'b1;
			end else begin
				full_cnt <= BW_W'(full_cnt + 1'b1);
			end
		end
	end

	wire logic [LINKS-1:0] dl      = s3_dv[LINKS-1:0];
	wire logic [LINKS-1:0] hit_blk = dl & link_blocked;
	// R08: detour over next triangle side
	wire logic [LINKS-1:0] detour  = {hit_blk[LINKS-2:0], hit_blk[LINKS-1]};
	wire logic             merged  = |(detour & dl & ~link_blocked);
	wire logic             lost    = |(detour & link_blocked);
	logic [DV_W-1:0]       em_dv;
	logic [ERR_W-1:0]      em_err;
	logic [PKT_W-1:0]      em_pkt;

	always_comb begin
		em_dv              = {s3_dv[DV_W-1:LINKS], (dl | detour) & ~link_blocked};
		em_err             = s3_err;
		em_pkt             = s3_pkt;
		// R12: link failure, packet dropped to management
		if (lost) begin
			em_dv            = em_dv | mon_dv;
			em_err[ERR_LINK] = 1'b1;
		end
		// R09: merged copy gets emergency type
		if (merged) begin
			em_pkt[TYPE_LSB +: 2] = PT_EMER;
			em_pkt = fix_par(em_pkt, s3_len);
		end
	end

	// Output register feeds the destination buffers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			lnk.out_valid <= 1'b0;
			lnk.dest      <= '0;
			lnk.out_pkt   <= '0;
			lnk.out_len   <= '0;
			lnk.out_err   <= '0;
			last_err      <= '0;
		end else if (out_free) begin
			lnk.out_valid <= s3_v;
			lnk.dest      <= em_dv;
			lnk.out_pkt   <= em_pkt;
			lnk.out_len   <= s3_len;
			lnk.out_err   <= em_err;
			if (s3_v && |em_err) begin
				last_err <= em_err;
			end
		end
	end

endmodule : packet_router

// ==== rtl/router_feeder.sv ====
`timescale 1ns/1ps
module router_feeder #(
	parameter int PROCS  = 20,
	parameter int LEVELS = 3,
	parameter int NSRC   = 2**LEVELS
)(
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 nrst,
	// Router side
	router_link_if.feeder                             lnk,
	// Sources: links first, then local processors
	input  wire logic [NSRC-1:0]                      src_valid,
	input  wire logic [router_pkg::PKT_W-1:0]         src_pkt [NSRC],
	input  wire logic [router_pkg::LEN_W-1:0]         src_len [NSRC],
	output logic [NSRC-1:0]                           src_ready,
	// Delivered packets
	output logic                                      dst_valid,
	output logic [router_pkg::LINKS+PROCS-1:0]        dst_vec,
	output logic [router_pkg::PKT_W-1:0]              dst_pkt,
	output logic [router_pkg::LEN_W-1:0]              dst_len,
	output logic [router_pkg::ERR_W-1:0]              dst_err,
	input  wire logic                                 dst_ready,
	// Output buffer full flags
	input  wire logic [router_pkg::LINKS-1:0]         out_full
);
	import router_pkg::*;

	localparam int NN = 2 * NSRC;

	// ****************************************
	// Tree storage, heap ordered
	// ****************************************
	logic             n_v [1:NN-1];     // Slot holds a packet
	logic [PKT_W-1:0] n_pkt [NN];       // Whole-packet buffer
	logic [LEN_W-1:0] n_len [NN];
	logic [TAG_W-1:0] n_tag [NN];       // Source bits so far
	logic [NN-1:1]    drained;          // Slot emptied this cycle
	logic [NSRC-1:1]  pick;             // Right child chosen
	logic [NSRC-1:1]  take;             // Node loads a child
	logic             last_r [1:NSRC-1]; // Fairness memory

	// Slot drain: root by router, others by parent
	for (genvar c = 1; c < NN; c++) begin : g_drain
		if (c == 1) begin : g_root
			assign drained[c] = n_v[c] && lnk.ready;
		end else begin : g_kid
			assign drained[c] = take[c/2] && (pick[c/2] == 1'(c % 2));
		end
	end

	// ****************************************
	// Leaves: one buffer per source
	// ****************************************
	for (genvar k = 0; k < NSRC; k++) begin : g_leaf
		wire logic fill = src_valid[k] && src_ready[k];
		logic      rdy;                // Leaf may accept
		assign src_ready[k] = rdy;
		always_ff @(posedge clk) begin
			if (!nrst) begin
				n_v[NSRC+k] <= 1'b0;
				rdy         <= 1'b0;
			end else begin
				if (fill) begin
					n_v[NSRC+k]   <= 1'b1;
					n_pkt[NSRC+k] <= src_pkt[k];
					n_len[NSRC+k] <= src_len[k];
					n_tag[NSRC+k] <= '0;
				end else if (drained[NSRC+k]) begin
					n_v[NSRC+k] <= 1'b0;
				end
				// R23: backpressure reaches each source
				rdy <= !(fill || (n_v[NSRC+k] && !drained[NSRC+k]));
			end
		end
	end

	// ****************************************
	// Two-input merge nodes
	// ****************************************
	// R15: binary tree of two-input arbiters
	for (genvar i = 1; i < NSRC; i++) begin : g_node
		wire logic lv   = n_v[2*i];
		wire logic rv   = n_v[2*i+1];
		wire logic free = !n_v[i] || drained[i];
		// Alternate when both children wait
		assign pick[i] = rv && (!lv || !last_r[i]);
		assign take[i] = free && (lv || rv);

		always_ff @(posedge clk) begin
			if (!nrst) begin
				n_v[i]    <= 1'b0;
				last_r[i] <= 1'b0;
			// R17: each node slot holds a whole packet
			end else if (take[i]) begin
				n_v[i]    <= 1'b1;
				last_r[i] <= pick[i];
				n_pkt[i]  <= pick[i] ? n_pkt[2*i+1] : n_pkt[2*i];
				n_len[i]  <= pick[i] ? n_len[2*i+1] : n_len[2*i];
				// R16: append one source bit per merge
				n_tag[i]  <= pick[i] ? {1'b1, n_tag[2*i+1][TAG_W-1:1]} :
					{1'b0, n_tag[2*i][TAG_W-1:1]};
			end else if (drained[i]) begin
				n_v[i] <= 1'b0;
			end
		end
	end

	// R02: root presents packet with its tag
	assign lnk.valid = n_v[1];
	assign lnk.pkt   = n_pkt[1];
	assign lnk.len   = n_len[1];
	assign lnk.tag   = n_tag[1];

	// ****************************************
	// Delivery side
	// ****************************************
	wire logic got = lnk.out_valid && lnk.out_ready;

	// R14: one packet at a time, in order
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dst_valid     <= 1'b0;
			dst_vec       <= '0;
			dst_pkt       <= '0;
			dst_len       <= '0;
			dst_err       <= '0;
			lnk.out_ready <= 1'b0;
			lnk.full      <= '0;
		end else begin
			if (got) begin
				dst_valid <= 1'b1;
				dst_vec   <= lnk.dest;
				dst_pkt   <= lnk.out_pkt;
				dst_len   <= lnk.out_len;
				dst_err   <= lnk.out_err;
			end else if (dst_ready) begin
				dst_valid <= 1'b0;
			end
			lnk.out_ready <= !(got || (dst_valid && !dst_ready));
			lnk.full      <= out_full;
		end
	end

endmodule : router_feeder

// ==== verification/router_link_sva.sv ====
`timescale 1ns/1ps
module router_link_sva #(
	parameter int PROCS      = 20,
	parameter int BLOCK_WAIT = 16
)(
	// Clock and reset
	input logic                                    clk,
	input logic                                    nrst,
	// Arbiter to router
	input logic                                    valid,
	input logic                                    ready,
	input logic [router_pkg::PKT_W-1:0]            pkt,
	input logic [router_pkg::LEN_W-1:0]            len,
	input logic [router_pkg::TAG_W-1:0]            tag,
	// Router to destination buffers
	input logic                                    out_valid,
	input logic                                    out_ready,
	input logic [router_pkg::LINKS+PROCS-1:0]      dest,
	input logic [router_pkg::PKT_W-1:0]            out_pkt,
	input logic [router_pkg::LEN_W-1:0]            out_len,
	input logic [router_pkg::ERR_W-1:0]            out_err,
	input logic [router_pkg::LINKS-1:0]            full
);
	import router_pkg::*;
	// ****************************************
	// Full-hold counters, one per link
	// ****************************************
	logic [7:0] held [LINKS];   // Saturating, so long stalls never wrap
	always_ff @(posedge clk) begin
		for (int l = 0; l < LINKS; l++) begin
			if (!nrst || !full[l]) held[l] <= 8'h0;
			else if (held[l] != 8'hff) held[l] <= held[l] + 8'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ****************************************
	// Handshake and routing checks
	// ****************************************
	a_offer_held: assert property (valid && !ready |=> valid && $stable(pkt) && $stable(len) && $stable(tag))
		else $error("offered packet changed before take");
	a_take_gap: assert property (valid && ready |=> !ready)
		else $error("two takes in adjacent cycles");
	a_result_held: assert property (out_valid && !out_ready |=> out_valid && $stable(dest) && $stable(out_pkt))
		else $error("routed packet changed before take");
	a_answer_soon: assert property (valid && ready && out_ready && !out_valid |-> ##[1:4] out_valid)
		else $error("no routed packet within four cycles");
	a_fault_to_mon: assert property (out_valid && (|out_err[2:0]) |-> dest[LINKS-1:0] == '0)
		else $error("faulty packet sent to a link");
	a_bad_length: assert property (out_valid && out_len != LEN_SHORT && out_len != LEN_LONG |-> out_err[ERR_LEN])
		else $error("illegal length not flagged");
	a_clean_parity: assert property (out_valid && out_err == '0 |->
		((out_len == LEN_LONG) ? ^out_pkt : ^out_pkt[SHORT_W-1:0]) == 1'b1)
		else $error("clean packet leaves with bad parity");
	// Margin of eight covers the full register and the stage delay
	for (genvar g = 0; g < LINKS; g++) begin : g_link
		a_blocked_unused: assert property ($rose(out_valid) && held[g] >= BLOCK_WAIT + 8 |-> !dest[g])
			else $error("packet routed onto a blocked link");
	end
	c_fault: cover property (out_valid && out_err != '0);
	c_merge: cover property (out_valid && out_pkt[7:6] == PT_EMER);
	c_local: cover property (valid && ready && tag == 3'h6);
endmodule : router_link_sva

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import router_pkg::*;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic              clk        = 1'b0;
	logic              nrst       = 1'b0;
	logic [7:0]        src_valid  = 8'h0;
	logic [PKT_W-1:0]  src_pkt [8];
	logic [LEN_W-1:0]  src_len [8];
	logic [7:0]        src_ready;
	logic              dst_valid;
	logic [25:0]       dst_vec;
	logic [PKT_W-1:0]  dst_pkt;
	logic [ERR_W-1:0]  dst_err;
	logic              dst_ready  = 1'b0;
	logic [5:0]        out_full   = 6'h0;
	logic              cfg_we     = 1'b0;
	logic [1:0]        cfg_sel    = 2'h0;
	logic [3:0]        cfg_addr   = 4'h0;
	logic [31:0]       cfg_data   = 32'h0;
	logic              phase_tick = 1'b0;
	logic [5:0]        link_reset = 6'h0;
	logic [1:0]        cur_phase;
	logic [5:0]        link_blocked;
	logic [ERR_W-1:0]  last_err;
	logic [PKT_W-1:0]  got;          // Last delivered packet
	logic [PKT_W-1:0]  pk;
	int                miscompares = 0;
	int                checked     = 0;
	localparam logic [25:0] MON = 26'h100;   // Management processor 2
	always #12.5 clk = ~clk;
	router_link_if link ();
	// Short counts keep the run brief
	packet_router #(.AM_N(16), .DIR_AW(4), .BLOCK_WAIT(2)) u_packet_router (.clk(clk), .nrst(nrst),
		.lnk(link), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .mon_id(5'h2),
		.phase_tick(phase_tick), .link_reset(link_reset), .cur_phase(cur_phase), .link_blocked(link_blocked),
		.last_err(last_err));
	router_feeder u_router_feeder (.clk(clk), .nrst(nrst), .lnk(link),
		.src_valid(src_valid), .src_pkt(src_pkt), .src_len(src_len), .src_ready(src_ready), .dst_valid(dst_valid),
		.dst_vec(dst_vec), .dst_pkt(dst_pkt), .dst_len(), .dst_err(dst_err), .dst_ready(dst_ready),
		.out_full(out_full));
	router_link_sva #(.BLOCK_WAIT(2)) u_router_link_sva (.clk(clk), .nrst(nrst), .valid(link.valid),
		.ready(link.ready), .pkt(link.pkt), .len(link.len), .tag(link.tag), .out_valid(link.out_valid),
		.out_ready(link.out_ready), .dest(link.dest), .out_pkt(link.out_pkt), .out_len(link.out_len),
		.out_err(link.out_err), .full(link.full));
	// ****************************************
	// Access tasks
	// ****************************************
	function automatic logic [PKT_W-1:0] mk(input logic [1:0] ty, input logic [1:0] ph, input logic [31:0] f);
		logic [PKT_W-1:0] p;
		p = {32'h0, f, ty, ph, 4'h0};
		p[0] = ~^p;   // Odd parity over the whole packet
		return p;
	endfunction : mk
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic cfg(input logic [1:0] s, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_sel <= s;
		cfg_addr <= a;
		cfg_data <= d;
		@(posedge clk);
		cfg_we <= 1'b0;
	endtask : cfg
	// Offer one packet and hold it until the feeder takes it
	task automatic tx(input int s, input logic [PKT_W-1:0] p, input logic [1:0] ln);
		@(posedge clk);
		src_valid[s] <= 1'b1;
		src_pkt[s] <= p;
		src_len[s] <= ln;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			if (src_ready[s] === 1'b1) break;
		end
		@(posedge clk);
		src_valid[s] <= 1'b0;
	endtask : tx
	// Wait for delivery, compare, then accept it
	task automatic rx(input logic [25:0] vec, input logic [3:0] err, input logic [3:0] em);
		for (int n = 0; n < 60 && dst_valid !== 1'b1; n++) @(negedge clk);
		chk(dst_valid, 1'b1, "no delivery");
		chk(dst_vec, vec, "destination");
		chk(dst_err & em, err, "error flags");
		got = dst_pkt;
		@(posedge clk);
		dst_ready <= 1'b1;
		@(posedge clk);
		dst_ready <= 1'b0;
	endtask : rx
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			src_pkt[i] = '0;
			src_len[i] = LEN_SHORT;
		end
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		cfg(CFG_DIR, 4'h3, 32'h8a);     // Links 0 and 2, odd parity
		cfg(CFG_DIR, 4'h5, 32'h86);     // Links 0 and 1
		cfg(CFG_ROUTE, 4'h0, 32'h840);
		cfg(CFG_MASK, 4'h0, 32'hf);     // Low nibble ignored
		cfg(CFG_KEY, 4'h0, 32'h12345678);
		tx(0, mk(PT_DIR, 2'h0, 32'h3), LEN_SHORT);
		rx(26'h5, 4'h0, 4'hf);
		pk = mk(PT_DIR, 2'h0, 32'h3);
		pk[71:40] = 32'h5a5a5a5a;     // Even bit count, parity unchanged
		tx(1, pk, LEN_LONG);
		rx(26'h5, 4'h0, 4'hf);
		chk(got[71:40], 32'h5a5a5a5a, "long tail");
		tx(2, mk(PT_GRP, 2'h0, 32'h1234567f), LEN_SHORT);
		rx(26'h840, 4'h0, 4'hf);
		tx(1, mk(PT_GRP, 2'h0, 32'h1), LEN_SHORT);
		rx(26'h10, 4'h0, 4'hf);
		tx(6, mk(PT_GRP, 2'h0, 32'h1), LEN_SHORT);
		rx(MON, 4'h0, 4'hf);
		tx(0, mk(PT_NBR, 2'h0, 32'h0), LEN_SHORT);
		rx(MON, 4'h0, 4'hf);
		tx(7, mk(PT_NBR, 2'h0, 32'h0), LEN_SHORT);
		rx(26'h3f, 4'h0, 4'hf);
		pk = mk(PT_DIR, 2'h0, 32'h3);
		pk[0] = ~pk[0];
		tx(0, pk, LEN_SHORT);
		rx(MON, 4'h1, 4'hf);
		chk(last_err, 4'h1, "last error");
		tx(0, mk(PT_DIR, 2'h0, 32'h3), 2'h0);
		rx(MON, 4'h4, 4'h4);
		tx(0, mk(PT_DIR, 2'h2, 32'h3), LEN_SHORT);
		rx(MON, 4'h2, 4'hf);
		@(posedge clk);
		phase_tick <= 1'b1;
		@(posedge clk);
		phase_tick <= 1'b0;
		@(negedge clk);
		chk(cur_phase, 2'h1, "phase");
		tx(7, mk(PT_NBR, 2'h0, 32'h0), LEN_SHORT);
		rx(26'h3f, 4'h0, 4'hf);
		chk(got[5:4], 2'h1, "stamped phase");
		// Hold link 0 full until it is judged blocked
		@(posedge clk);
		out_full <= 6'h1;
		repeat (30) @(posedge clk);
		@(negedge clk);
		chk(link_blocked, 6'h1, "blocked links");
		tx(0, mk(PT_DIR, 2'h0, 32'h5), LEN_SHORT);
		rx(26'h2, 4'h0, 4'hf);
		chk(got[7:6], PT_EMER, "merged type");
		tx(0, mk(PT_DIR, 2'h0, 32'h3), LEN_SHORT);
		rx(26'h6, 4'h0, 4'hf);
		@(posedge clk);
		link_reset <= 6'h1;
		@(posedge clk);
		@(negedge clk);
		chk(link_blocked, 6'h0, "blocked after link reset");
		@(posedge clk);
		link_reset <= 6'h0;
		out_full <= 6'h0;
		repeat (4) @(posedge clk);
		tally_and_finish();
	end
endmodule : testbench
